//--- logic/gpt_pkg.sv
package gpt_pkg;

   // ----------------------------------------
   // sizes and indexes
   // ----------------------------------------
   localparam int TW = 16;        // timer width
   localparam int NT = 5;         // number of timers
   localparam int NP = 11;        // synchronised pins
   localparam int NF = 8;         // request flags
   localparam int PRE_W = 10;     // prescaler counter width
   localparam int BASE_A = 3;     // group a divisor 8 is 2**3
   localparam int BASE_B = 2;     // group b divisor 4 is 2**2
   localparam int IX_CA = 0;      // core_timer_a
   localparam int IX_LO = 1;      // aux_timer_lo
   localparam int IX_HI = 2;      // aux_timer_hi
   localparam int IX_CB = 3;      // core_timer_b
   localparam int IX_AB = 4;      // aux_timer_b
   localparam int IX_DIR = 5;     // first direction pin in the pin vector
   localparam int IX_CAP = 10;    // capture_input_pin in the pin vector
   localparam int FL_CAP_LO = 5;  // capture into aux_timer_lo
   localparam int FL_CAP_HI = 6;  // capture into aux_timer_hi
   localparam int FL_CAP_B = 7;   // capture into capture_reload_reg
   localparam logic [TW-1:0] T_MAX = 16'hFFFF;
   localparam logic [TW-1:0] T_ZERO = 16'h0000;
   localparam logic [TW-1:0] T_ONE = 16'h0001;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {MODE_TIMER = 2'h0, MODE_GATED = 2'h1,
      MODE_COUNTER = 2'h3, MODE_INCR = 2'h2} mode_type;
   typedef enum logic [1:0] {ROLE_COUNT = 2'h0, ROLE_CONCAT = 2'h1,
      ROLE_RELOAD = 2'h3, ROLE_CAPTURE = 2'h2} role_type;
   typedef enum logic [1:0] {EDGE_RISE = 2'h0, EDGE_FALL = 2'h1,
      EDGE_BOTH = 2'h3, EDGE_NONE = 2'h2} edge_type;

   typedef struct packed {
      mode_type mode;      // basic mode
      role_type role;      // aux timers only
      logic [2:0] sel;     // input_select_field
      logic down;          // software direction
      logic dir_pin_en;    // direction_input_pin may invert it
      logic gate_high;     // active gate level
      edge_type cnt_edge;  // counter edges, capture and reload pin edges
      edge_type tl_edge;   // toggle latch transition for concat or reload
      logic ext_reload;    // reload on input pin edge
   } cfg_type;

   typedef struct packed {
      logic pin_en;        // capture from capture_input_pin
      edge_type cap_edge;  // its edge
      logic from_core_in;  // capture on core_a_count_pin edges
      logic from_core_dir; // capture on core_a_dir_pin edges
      logic clear_aux;     // clear aux_timer_b after capture
      logic reload_core_b; // reload core_timer_b on its wrap
   } capb_cfg_type;

   typedef struct packed {
      logic [NT-1:0] en;   // write strobe per timer
      logic cap_en;        // write strobe for capture_reload_reg
      logic [TW-1:0] data; // write data
   } wr_type;

   typedef struct packed {
      logic [NP-1:0] s1;
      logic [NP-1:0] s2;
      logic [NP-1:0] s3;
      logic [NP-1:0] filt;
      logic [NP-1:0] prev;
      logic [PRE_W-1:0] presc;
      logic [NT-1:0][TW-1:0] tmr;
      logic tl_a;
      logic tl_b;
      logic [TW-1:0] capreg;
      logic [NF-1:0] flags;
      logic ovf_b;
   } state_type;

   localparam state_type ST_RESET = '0;

endpackage

//--- logic/gpt_unit.sv
`timescale 1ns/10ps
module gpt_unit (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // configuration
   input wire gpt_pkg::cfg_type [gpt_pkg::NT-1:0] cfg_i,
   input wire gpt_pkg::capb_cfg_type capb_cfg_i,
   // software writes and flag clears
   input wire gpt_pkg::wr_type wr_i,
   input wire logic [gpt_pkg::NF-1:0] flag_clr_i,
   // external pins
   input wire logic [gpt_pkg::NT-1:0] timer_input_pin_i,
   input wire logic [gpt_pkg::NT-1:0] direction_input_pin_i,
   input wire logic capture_input_pin_i,
   // timer state
   output logic [gpt_pkg::NT-1:0][gpt_pkg::TW-1:0] timer_o,
   output logic [gpt_pkg::TW-1:0] capture_reload_reg_o,
   output logic toggle_output_pin_a_o,
   output logic toggle_output_pin_b_o,
   // requests and compare-unit clock
   output logic [gpt_pkg::NF-1:0] flags_o,
   output logic core_b_wrap_o
);
   import gpt_pkg::*;

   // ----------------------------------------
   // helper functions
   // ----------------------------------------

   // edge selection
   function automatic logic edge_hit(edge_type e, logic r, logic f);
      logic h;
      h = 1'b0;
      unique case (e)
         EDGE_RISE: h = r;
         EDGE_FALL: h = f;
         EDGE_BOTH: h = r | f;
         EDGE_NONE: h = 1'b0;
      endcase
      return h;
   endfunction

   // prescaler tick: low base+sel bits all ones
   function automatic logic presc_hit(logic [PRE_W-1:0] cnt, logic [2:0] sel, int base);
      logic [PRE_W-1:0] m;
      m = PRE_W'((1 << (base + int'(sel))) - 1);
      return (cnt & m) == m;
   endfunction

   // count enable and direction of one timer
   function automatic logic [1:0] step(cfg_type c, logic tick, logic a, logic ar, logic af,
                                       logic b, logic br, logic bf, logic tr, logic tf);
      logic en;
      logic dn;
      en = 1'b0;
      dn = c.down ^ (c.dir_pin_en & b);
      unique case (c.mode)
         MODE_TIMER: en = tick;
         MODE_GATED: en = tick & (a == c.gate_high);
         MODE_COUNTER: en = edge_hit(c.cnt_edge, ar, af);
         MODE_INCR:
         begin
            en = ar | af | br | bf;
            dn = c.down ^ ((ar | af) ? (a == b) : (a != b));
         end
      endcase
      unique case (c.role)
         ROLE_COUNT: en = en;
         ROLE_CONCAT: en = edge_hit(c.tl_edge, tr, tf);
         ROLE_RELOAD, ROLE_CAPTURE: en = 1'b0;
      endcase
      return {en, dn};
   endfunction

   // one count step, wrap flag on top
   function automatic logic [TW:0] bump(logic [TW-1:0] v, logic en, logic dn);
      logic wrap;
      logic [TW-1:0] n;
      wrap = en & (dn ? (v == T_ZERO) : (v == T_MAX));
      n = v;
      if (en)
      begin
         n = dn ? v - T_ONE : v + T_ONE;
      end
      return {wrap, n};
   endfunction

   // ----------------------------------------
   // state and working signals
   // ----------------------------------------
   state_type st_q;                   // all state
   state_type st_d;                   // next state
   logic [NP-1:0] diff;               // second and third stage disagree
   logic [NP-1:0] rise;               // filtered rising edges
   logic [NP-1:0] fall;               // filtered falling edges
   logic [NT-1:0] en_v;               // count enables
   logic [NT-1:0] dn_v;               // count directions
   logic [NT-1:0] ovf_v;              // wraps this cycle
   logic [NT-1:0][TW-1:0] nxt;        // counted values
   logic [1:0] cap_v;                 // aux captures lo and hi
   logic capb_v;                      // group b capture
   logic tl_ra;                       // latch a rises
   logic tl_fa;                       // latch a falls
   logic tr;                          // latch rise seen by a timer
   logic tf;                          // latch fall seen by a timer
   logic tick;                        // prescaler tick of a timer
   logic hit;                         // aux pin edge
   logic [1:0] sv;                    // step result
   int core;                          // core index of a timer's group
   cfg_type c_v;                      // working configuration

   // ----------------------------------------
   // next state
   // ----------------------------------------

   // pins, counting, reload, capture, flags
   always_comb
   begin
      st_d = st_q;
      ovf_v = '0;
      en_v = '0;
      dn_v = '0;
      nxt = st_q.tmr;
      cap_v = '0;
      tr = 1'b0;
      tf = 1'b0;
      tick = 1'b0;
      hit = 1'b0;
      sv = '0;
      core = IX_CA;
      c_v = cfg_i[IX_CA];
      diff = st_q.s2 ^ st_q.s3;
      st_d.s1 = {capture_input_pin_i, direction_input_pin_i, timer_input_pin_i};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.filt = (st_q.s2 & ~diff) | (st_q.filt & diff);
      st_d.prev = st_q.filt;
      rise = st_q.filt & ~st_q.prev;
      fall = ~st_q.filt & st_q.prev;
      // free running prescaler
      st_d.presc = PRE_W'(st_q.presc + 1'b1);
      // cores come first so their aux timers see this cycle's latch change
      for (int i = 0; i < NT; i++)
      begin
         c_v = cfg_i[i];
         core = (i < IX_CB) ? IX_CA : IX_CB;
         if (i == core)
         begin
            c_v.role = ROLE_COUNT;
         end
         if (i < IX_CB)
         begin
            tick = presc_hit(st_q.presc, c_v.sel, BASE_A);
            tr = ovf_v[core] & ~st_q.tl_a;
            tf = ovf_v[core] & st_q.tl_a;
         end
         else
         begin
            tick = presc_hit(st_q.presc, c_v.sel, BASE_B);
            tr = ovf_v[core] & ~st_q.tl_b;
            tf = ovf_v[core] & st_q.tl_b;
         end
         sv = step(c_v, tick, st_q.filt[i], rise[i], fall[i], st_q.filt[IX_DIR + i],
                   rise[IX_DIR + i], fall[IX_DIR + i], tr, tf);
         en_v[i] = sv[1];
         dn_v[i] = sv[0];
         {ovf_v[i], nxt[i]} = bump(st_q.tmr[i], en_v[i], dn_v[i]);
      end
      st_d.tmr = nxt;
      tl_ra = ovf_v[IX_CA] & ~st_q.tl_a;
      tl_fa = ovf_v[IX_CA] & st_q.tl_a;
      st_d.tl_a = st_q.tl_a ^ ovf_v[IX_CA];
      st_d.tl_b = st_q.tl_b ^ ovf_v[IX_CB];
      st_d.ovf_b = ovf_v[IX_CB];
      // aux timers of group a as reload or capture registers
      for (int j = IX_LO; j <= IX_HI; j++)
      begin
         c_v = cfg_i[j];
         hit = edge_hit(c_v.cnt_edge, rise[j], fall[j]);
         if (c_v.role == ROLE_RELOAD &&
             ((c_v.ext_reload & hit) | edge_hit(c_v.tl_edge, tl_ra, tl_fa)))
         begin
            st_d.tmr[IX_CA] = st_q.tmr[j];
         end
         if (c_v.role == ROLE_CAPTURE && hit)
         begin
            st_d.tmr[j] = st_q.tmr[IX_CA];
            cap_v[j - IX_LO] = 1'b1;
         end
      end
      if (ovf_v[IX_CB] & capb_cfg_i.reload_core_b)
      begin
         st_d.tmr[IX_CB] = st_q.capreg;
      end
      capb_v = (capb_cfg_i.pin_en &
                edge_hit(capb_cfg_i.cap_edge, rise[IX_CAP], fall[IX_CAP])) |
               (capb_cfg_i.from_core_in & (rise[IX_CA] | fall[IX_CA])) |
               (capb_cfg_i.from_core_dir & (rise[IX_DIR + IX_CA] | fall[IX_DIR + IX_CA]));
      if (capb_v)
      begin
         st_d.capreg = st_q.tmr[IX_AB];
         if (capb_cfg_i.clear_aux)
         begin
            st_d.tmr[IX_AB] = T_ZERO;
         end
      end
      // software writes win over counting
      for (int i = 0; i < NT; i++)
      begin
         if (wr_i.en[i])
         begin
            st_d.tmr[i] = wr_i.data;
         end
      end
      if (wr_i.cap_en)
      begin
         st_d.capreg = wr_i.data;
      end
      st_d.flags = (st_q.flags & ~flag_clr_i) | {capb_v, cap_v, ovf_v};
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         st_q <= ST_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign timer_o = st_q.tmr;
   assign capture_reload_reg_o = st_q.capreg;
   assign toggle_output_pin_a_o = st_q.tl_a;
   assign toggle_output_pin_b_o = st_q.tl_b;
   assign flags_o = st_q.flags;
   assign core_b_wrap_o = st_q.ovf_b;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   pin_filter_a: assert property ($stable(st_q.s1) [*5] |-> st_q.filt == st_q.s1)
      else $error("filtered pins do not follow stable inputs");

   presc_pace_a: assert property ((cfg_i[IX_CA].mode == MODE_TIMER &&
      cfg_i[IX_CA].sel == 3'h0 && !wr_i.en[IX_CA] &&
      st_q.presc[BASE_A-1:0] != 3'h7) |=> $stable(st_q.tmr[IX_CA]))
      else $error("core a counted without a prescaler tick");

   gate_hold_a: assert property ((cfg_i[IX_CA].mode == MODE_GATED &&
      st_q.filt[IX_CA] != cfg_i[IX_CA].gate_high && !wr_i.en[IX_CA])
      |=> $stable(st_q.tmr[IX_CA]))
      else $error("core a counted with gate closed");

   latch_a_flip_a: assert property (ovf_v[IX_CA] |=> st_q.tl_a != $past(st_q.tl_a))
      else $error("latch a missed a wrap");

   latch_b_flip_a: assert property (ovf_v[IX_CB] |=>
      (st_q.tl_b != $past(st_q.tl_b) && core_b_wrap_o) ##1
      (core_b_wrap_o == $past(ovf_v[IX_CB])))
      else $error("latch b or wrap pulse wrong");

   aux_stop_a: assert property ((cfg_i[IX_LO].role == ROLE_RELOAD &&
      !wr_i.en[IX_LO]) |=> $stable(st_q.tmr[IX_LO]))
      else $error("aux lo counted while reloading");

   cap_value_a: assert property ((cap_v[0] && !wr_i.en[IX_LO])
      |=> st_q.tmr[IX_LO] == $past(st_q.tmr[IX_CA]) && st_q.flags[FL_CAP_LO])
      else $error("aux lo capture wrong");

   capb_clear_a: assert property ((capb_v && capb_cfg_i.clear_aux &&
      !wr_i.en[IX_AB] && !wr_i.cap_en)
      |=> st_q.tmr[IX_AB] == T_ZERO && st_q.capreg == $past(st_q.tmr[IX_AB]))
      else $error("group b capture or clear wrong");

   flag_keep_a: assert property ((st_q.flags[IX_CB] && !flag_clr_i[IX_CB])
      |=> st_q.flags[IX_CB])
      else $error("flag lost without clear");

   // main scenarios
   pwm_reload_c: cover property (cfg_i[IX_LO].role == ROLE_RELOAD &&
      cfg_i[IX_HI].role == ROLE_RELOAD && ovf_v[IX_CA] ##[1:300] ovf_v[IX_CA]);
   incr_down_c: cover property (cfg_i[IX_CA].mode == MODE_INCR && en_v[IX_CA] && dn_v[IX_CA]);
   capb_c: cover property (capb_v && capb_cfg_i.from_core_in);

endmodule

//--- dv/gpt_pins_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// far side: event, gate and sensor lines
// ----------------------------------------
module gpt_pins_model (
   // clock
   input wire logic clk_i,
   // lines into the unit
   output logic [gpt_pkg::NT-1:0] timer_input_pin_o,
   output logic [gpt_pkg::NT-1:0] direction_input_pin_o,
   output logic capture_input_pin_o
);
   import gpt_pkg::*;
   logic [1:0] phase; // sensor position, binary count; the lines carry its gray code
   // lines idle low from time zero
   initial
   begin
      timer_input_pin_o = '0;
      direction_input_pin_o = '0;
      capture_input_pin_o = 1'b0;
      phase = 2'h0;
   end
   // hold past filter
   // each level stands six cycles, beyond the synchroniser delay
   task automatic level(input int i, input logic v);
      @(negedge clk_i);
      if (i < NT)
         timer_input_pin_o[i] = v;
      else
         capture_input_pin_o = v;
      repeat (6) @(negedge clk_i);
   endtask
   // one full pulse: rise then fall
   task automatic pulse(input int i);
      level(i, 1'b1);
      level(i, 1'b0);
   endtask
   task automatic dir(input int i, input logic v);
      @(negedge clk_i);
      direction_input_pin_o[i] = v;
      repeat (6) @(negedge clk_i);
   endtask
   // quadrature step order
   // a leads b going forward: 00, 10, 11, 01
   task automatic quad(input int i, input logic up);
      @(negedge clk_i);
      phase = up ? phase + 2'h1 : phase - 2'h1;
      timer_input_pin_o[i] = phase[1] ^ phase[0];
      direction_input_pin_o[i] = phase[1];
      repeat (6) @(negedge clk_i);
   endtask
endmodule

//--- dv/gpt_unit_tb_top.sv
`timescale 1ns/10ps
module gpt_unit_tb_top;
   import gpt_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_i;
   logic reset_n_i;
   cfg_type [NT-1:0] cfg; // per-timer setup
   capb_cfg_type capb; // group b capture setup
   wr_type wr; // software writes
   logic [NF-1:0] clr; // flag clears
   logic [NT-1:0] tin;
   logic [NT-1:0] din;
   logic cin;
   logic [NT-1:0][TW-1:0] tmr;
   logic [TW-1:0] capreg;
   logic tla;
   logic tlb;
   logic [NF-1:0] flags;
   logic wrap_b;
   int failures = 0;
   int checked = 0;
   int wraps = 0; // core b wrap pulses seen
   gpt_unit u_gpt_unit (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg),
      .capb_cfg_i(capb), .wr_i(wr), .flag_clr_i(clr), .timer_input_pin_i(tin),
      .direction_input_pin_i(din), .capture_input_pin_i(cin), .timer_o(tmr),
      .capture_reload_reg_o(capreg), .toggle_output_pin_a_o(tla),
      .toggle_output_pin_b_o(tlb), .flags_o(flags), .core_b_wrap_o(wrap_b));
   gpt_pins_model u_gpt_pins_model (.clk_i(clk_i), .timer_input_pin_o(tin),
      .direction_input_pin_o(din), .capture_input_pin_o(cin));
   // 100 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // count compare-unit clock pulses
   always @(posedge clk_i)
      if (wrap_b === 1'b1)
         wraps <= wraps + 1;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [TW-1:0] got, input logic [TW-1:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // given mode and role on rising pin edges, up, gate high, no latch use
   task automatic cf(input int i, input mode_type m, input role_type r);
      @(negedge clk_i);
      cfg[i] = '{mode: m, role: r, sel: 3'h0, down: 1'b0, dir_pin_en: 1'b0,
         gate_high: 1'b1, cnt_edge: EDGE_RISE, tl_edge: EDGE_NONE, ext_reload: 1'b0};
   endtask
   // index NT writes the capture/reload register
   task automatic wt(input int i, input logic [TW-1:0] v);
      @(negedge clk_i);
      if (i < NT)
         wr.en[i] = 1'b1;
      else
         wr.cap_en = 1'b1;
      wr.data = v;
      @(negedge clk_i);
      wr.en = '0;
      wr.cap_en = 1'b0;
      chk((i < NT) ? tmr[i] : capreg, v, "write");
   endtask
   task automatic fclr(input int b);
      @(negedge clk_i);
      clr[b] = 1'b1;
      @(negedge clk_i);
      clr = '0;
      chk(TW'(flags[b]), T_ZERO, "flag clear");
   endtask
   // wait, bounded, while a timer still shows v
   task automatic till(input int i, input logic [TW-1:0] v);
      for (int n = 0; n < 2100 && tmr[i] === v; n++)
         @(negedge clk_i);
   endtask
   task automatic test_done();
      $display("checks %0d, failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // divisor for codes 0 and 7 in both groups
   task automatic t_prescale();
      int i;
      int per;
      for (int g = 0; g < 2; g++)
         for (int s = 0; s < 8; s += 7)
         begin
            i = g ? IX_CB : IX_CA;
            per = (g ? 4 : 8) << s;
            cf(i, MODE_TIMER, ROLE_COUNT);
            cfg[i].sel = 3'(s);
            wt(i, T_ZERO);
            till(i, T_ZERO);
            repeat (3 * per - 1) @(negedge clk_i);
            chk(tmr[i], 16'h0003, "prescale early");
            @(negedge clk_i);
            chk(tmr[i], 16'h0004, "prescale step");
            cf(i, MODE_COUNTER, ROLE_COUNT);
         end
      $display("prescale done");
   endtask
   task automatic t_gate();
      cf(0, MODE_GATED, ROLE_COUNT);
      wt(0, T_ZERO);
      repeat (64) @(negedge clk_i);
      chk(tmr[0], T_ZERO, "gate closed");
      u_gpt_pins_model.level(0, 1'b1);
      till(0, T_ZERO);
      repeat (16) @(negedge clk_i);
      chk(tmr[0], 16'h0003, "gate open");
      cfg[0].gate_high = 1'b0;
      repeat (64) @(negedge clk_i);
      chk(tmr[0], 16'h0003, "low gate closed");
      u_gpt_pins_model.level(0, 1'b0);
      till(0, 16'h0003);
      repeat (16) @(negedge clk_i);
      chk(tmr[0], 16'h0006, "low gate open");
      $display("gate done");
   endtask
   task automatic t_wrap();
      cf(0, MODE_COUNTER, ROLE_COUNT);
      cf(2, MODE_COUNTER, ROLE_CONCAT);
      cfg[2].tl_edge = EDGE_BOTH;
      wt(2, 16'h0100);
      wt(0, T_MAX);
      u_gpt_pins_model.pulse(0);
      chk(tmr[0], T_ZERO, "overflow");
      chk(TW'(tla), T_ONE, "latch a set");
      chk(TW'(flags[IX_CA]), T_ONE, "wrap flag");
      chk(tmr[2], 16'h0101, "chain up");
      fclr(IX_CA);
      cfg[0].dir_pin_en = 1'b1;
      u_gpt_pins_model.dir(0, 1'b1);
      u_gpt_pins_model.pulse(0);
      chk(tmr[0], T_MAX, "pin down");
      chk(TW'(tla), T_ZERO, "latch a back");
      chk(tmr[2], 16'h0102, "chain again");
      u_gpt_pins_model.dir(0, 1'b0);
      $display("wrap done");
   endtask
   task automatic t_quad();
      cf(0, MODE_INCR, ROLE_COUNT);
      wt(0, 16'h0010);
      repeat (4) u_gpt_pins_model.quad(0, 1'b1);
      chk(tmr[0], 16'h0014, "sensor forward");
      repeat (2) u_gpt_pins_model.quad(0, 1'b0);
      chk(tmr[0], 16'h0012, "sensor back");
      repeat (2) u_gpt_pins_model.quad(0, 1'b1);
      chk(tmr[0], 16'h0014, "sensor return");
      $display("quad done");
   endtask
   task automatic t_roles();
      cf(0, MODE_COUNTER, ROLE_COUNT);
      cf(1, MODE_TIMER, ROLE_CAPTURE);
      wt(0, 16'h1234);
      wt(1, T_ZERO);
      repeat (64) @(negedge clk_i);
      chk(tmr[1], T_ZERO, "capture role stopped");
      u_gpt_pins_model.pulse(1);
      chk(tmr[1], 16'h1234, "capture core");
      chk(TW'(flags[FL_CAP_LO]), T_ONE, "capture flag");
      fclr(FL_CAP_LO);
      cf(2, MODE_TIMER, ROLE_RELOAD);
      cfg[2].ext_reload = 1'b1;
      wt(2, 16'h0ABC);
      u_gpt_pins_model.pulse(2);
      chk(tmr[0], 16'h0ABC, "reload pin");
      chk(tmr[2], 16'h0ABC, "reload role stopped");
      cf(1, MODE_COUNTER, ROLE_RELOAD);
      cfg[1].tl_edge = EDGE_RISE;
      cf(2, MODE_COUNTER, ROLE_RELOAD);
      cfg[2].tl_edge = EDGE_FALL;
      wt(1, 16'hFFFE);
      wt(2, 16'hFFFD);
      wt(0, T_MAX);
      u_gpt_pins_model.pulse(0);
      chk(tmr[0], 16'hFFFE, "pwm first phase");
      repeat (2) u_gpt_pins_model.pulse(0);
      chk(tmr[0], 16'hFFFD, "pwm second phase");
      chk(TW'(tla), T_ZERO, "pwm latch");
      $display("roles done");
   endtask
   task automatic t_group_b();
      int n;
      cf(3, MODE_COUNTER, ROLE_COUNT);
      cf(4, MODE_COUNTER, ROLE_COUNT);
      capb = '{pin_en: 1'b1, cap_edge: EDGE_RISE, from_core_in: 1'b0,
         from_core_dir: 1'b0, clear_aux: 1'b1, reload_core_b: 1'b1};
      wt(4, 16'h5555);
      u_gpt_pins_model.pulse(NT);
      chk(capreg, 16'h5555, "capture b");
      chk(tmr[4], T_ZERO, "aux b cleared");
      chk(TW'(flags[FL_CAP_B]), T_ONE, "capture b flag");
      cfg[4].cnt_edge = EDGE_FALL;
      u_gpt_pins_model.level(4, 1'b1);
      chk(tmr[4], T_ZERO, "aux b rise ignored");
      u_gpt_pins_model.level(4, 1'b0);
      chk(tmr[4], T_ONE, "aux b falling edge");
      cfg[4].dir_pin_en = 1'b1;
      u_gpt_pins_model.dir(4, 1'b1);
      u_gpt_pins_model.pulse(4);
      chk(tmr[4], T_ZERO, "aux b pin down");
      u_gpt_pins_model.dir(4, 1'b0);
      cf(4, MODE_COUNTER, ROLE_CONCAT);
      cfg[4].tl_edge = EDGE_BOTH;
      cfg[3].down = 1'b1;
      wt(NT, 16'h1357);
      wt(3, T_ZERO);
      n = wraps;
      u_gpt_pins_model.pulse(3);
      chk(tmr[3], 16'h1357, "underflow reload");
      chk(TW'(wraps - n), T_ONE, "compare clock");
      chk(TW'(tlb), T_ONE, "latch b");
      chk(tmr[4], T_ONE, "aux b chained");
      capb.pin_en = 1'b0;
      capb.from_core_in = 1'b1;
      capb.clear_aux = 1'b0;
      wt(4, 16'h0077);
      u_gpt_pins_model.pulse(0);
      chk(capreg, 16'h0077, "capture from core pin");
      capb.from_core_in = 1'b0;
      capb.from_core_dir = 1'b1;
      wt(4, 16'h0099);
      u_gpt_pins_model.dir(0, 1'b1);
      chk(capreg, 16'h0099, "capture from core dir pin");
      u_gpt_pins_model.dir(0, 1'b0);
      capb.from_core_dir = 1'b0;
      capb.pin_en = 1'b1;
      capb.cap_edge = EDGE_FALL;
      wt(4, 16'h00AA);
      u_gpt_pins_model.level(NT, 1'b1);
      chk(capreg, 16'h0099, "capture rise ignored");
      u_gpt_pins_model.level(NT, 1'b0);
      chk(capreg, 16'h00AA, "capture on fall");
      $display("group b done");
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      reset_n_i = 1'b0;
      capb = '0;
      wr = '0;
      clr = '0;
      for (int i = 0; i < NT; i++)
         cfg[i] = '{MODE_COUNTER, ROLE_COUNT, 3'h0, 1'b0, 1'b0, 1'b1, EDGE_RISE, EDGE_NONE, 1'b0};
      repeat (10) @(negedge clk_i);
      reset_n_i = 1'b1;
      t_prescale();
      t_gate();
      t_wrap();
      t_quad();
      t_roles();
      t_group_b();
      test_done();
   end
   // cut a hang short
   initial
   begin
      #500000;
      failures++;
      $display("Error %0t watchdog expired", $time);
      test_done();
   end
endmodule
